// ### rtl/spi_fuse_pkg.sv
/*
  Shared constants and types for the serial client port and its fuse readout.
  Assumes a single core clock domain; link pins are sampled, never used as clocks.
*/
package spi_fuse_pkg;

  // ==========================================================
  // word and frame geometry
  localparam int WORD_MAX = 16;
  localparam int WORD_MIN = 8;
  localparam int ADDR_BITS = 32;
  localparam int CODE_BITS = 16;
  localparam int DATA_BITS = 32;
  localparam int HDR_BITS = ADDR_BITS + CODE_BITS;
  localparam int KEY_BITS = 128;
  localparam int CTRL_BITS = 32;
  localparam int FBIT_W = 12;
  localparam int LEN_W = 5;

  // ==========================================================
  // command codes and unlock words
  localparam logic [CODE_BITS-1:0] CODE_UNLOCK = 16'hDE05;
  localparam logic [CODE_BITS-1:0] CODE_READ_DEC = 16'h000D;
  localparam logic [CODE_BITS-1:0] CODE_READ_AUTH = 16'h000E;
  localparam logic [CODE_BITS-1:0] CODE_READ_CTRL = 16'h0010;
  localparam logic [CODE_BITS-1:0] CODE_READOUT = 16'h0011;
  localparam logic [DATA_BITS-1:0] UNLOCK_FIRST = 32'h5345ACBA;
  localparam logic [DATA_BITS-1:0] UNLOCK_SECOND = 32'hACBA5345;

  // ==========================================================
  // reset values and counts
  localparam logic [WORD_MAX-1:0] SHIFT_RESET = 16'h0000;
  localparam logic [FBIT_W-1:0] FBIT_MAX = 12'hFFF;
  localparam logic [LEN_W-1:0] LEN_MIN = 5'h08;
  localparam logic [LEN_W-1:0] LEN_MAX = 5'h10;
  localparam logic [2:0] PIN_RESET = 3'h1;
  localparam int RX_DEPTH = 2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {LOCKED, HALF_OPEN, OPEN} unlock_state_type;
  typedef enum logic [1:0] {TAMP_DEC, TAMP_AUTH, TAMP_CTRL} tamper_sel_type;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic cs_n;
  } spi_in_type;

  typedef struct packed {
    logic miso;
    logic miso_oe;
  } spi_out_type;

  typedef struct packed {
    logic [KEY_BITS-1:0] decryption_key;
    logic [KEY_BITS-1:0] auth_key;
    logic [CTRL_BITS-1:0] ctrl;
  } fuse_bank_type;

  typedef struct packed {
    logic valid;
    logic [WORD_MAX-1:0] data;
  } word_type;

endpackage : spi_fuse_pkg

// ### rtl/pin_sync.sv
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous to mclk_i; only stage two is read outside.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] pins_i,
  output logic [WIDTH-1:0] pins_o
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type s;
  sync_state_type next_s;

  always_comb begin
    next_s.stage1 = pins_i;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= {RESET_VALUE, RESET_VALUE};
    end else begin
      s <= next_s;
    end
  end

  assign pins_o = s.stage2;

endmodule : pin_sync

// ### rtl/word_buffer.sv
/*
  Small FIFO of received words, valid/ready on both sides.
  Assumes the drain side may stall; the filling side must honour in_ready_o.
*/
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } buf_state_type;

  buf_state_type s;
  buf_state_type next_s;
  logic push;
  logic pop;

  assign in_ready_o = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o = s.mem[s.rd];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data_i;
      next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + AW'(1);
    end
    if (pop) begin
      next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + AW'(1);
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : word_buffer

// ### rtl/spi_client_fuse_readout.sv
/*
  Serial client port with bootloader unlock and fuse readout through tamper registers.
  Assumes an external host drives sck, mosi and active-low chip select; core side
  writes transmit words and drains received words on mclk_i.
*/
// How it works
// - only a client: pins sck, mosi, cs come in; only miso goes out.
// - word length 8 to 16 bits, same length on host and device.
// - shifting follows sck edges only; pins pass a two-flop crossing first.
// - four modes set shift edge, capture edge and idle level of sck.
// - host and device use the same mode before any transfer.
// - sck ignored until cs falls; cs fall arms clock and loads transmit data.
// - bits go out on miso and come in from mosi on mode edges.
// - transfer sends current shift contents, the last received word if none written.
// - shift register clears on reset, so early transfers send zeros.
// - first write after a load, made while no frame is active, goes straight into the shift register.
// - later writes overwrite a holding word, loaded when cs falls or a word completes.
// - with nothing new written the last received word is sent next.
// - two unlock commands with fixed data must precede fuse commands.
// - code 000D copies decryption key fuses into their tamper register.
// - code 000E copies authentication key fuses into their tamper register.
// - code 0010 copies control fuses into their tamper register.
// - code 0011 data words return the selected tamper register on miso.
`timescale 1ns/1ps
module spi_client_fuse_readout (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire spi_fuse_pkg::spi_in_type spi_i,
  output spi_fuse_pkg::spi_out_type spi_o,
  input wire logic [1:0] mode_i,
  input wire logic [spi_fuse_pkg::LEN_W-1:0] word_len_i,
  input wire spi_fuse_pkg::word_type tx_i,
  output logic tx_ready_o,
  output spi_fuse_pkg::word_type rx_o,
  input wire logic rx_ready_i,
  input wire spi_fuse_pkg::fuse_bank_type fuse_i,
  output logic overrun_o,
  output logic unlocked_o,
  output logic busy_o
);
  import spi_fuse_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic sck_q;
    logic cs_n_q;
    logic active;
    logic [WORD_MAX-1:0] shift;
    logic [WORD_MAX-1:0] hold;
    logic hold_valid;
    logic tx_fresh;
    logic cap_bit;
    logic skip;
    logic [LEN_W-1:0] bit_cnt;
    logic [FBIT_W-1:0] fbit;
    logic [FBIT_W-1:0] out_idx;
    logic [HDR_BITS-1:0] hdr;
    logic [DATA_BITS-1:0] dword;
    unlock_state_type unlock;
    tamper_sel_type sel;
    logic [KEY_BITS-1:0] tamper_dec;
    logic [KEY_BITS-1:0] tamper_auth;
    logic [CTRL_BITS-1:0] tamper_ctrl;
    logic [WORD_MAX-1:0] rx_word;
    logic rx_push;
    logic overrun;
    logic miso;
  } state_type;

  state_type s;
  state_type next_s;

  // ==========================================================
  // pin crossing
  spi_in_type pins;

  pin_sync #(
    .WIDTH(3),
    .RESET_VALUE(PIN_RESET)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .pins_i(spi_i),
    .pins_o(pins)
  );

  // ==========================================================
  // mode and word length decode
  logic cpha;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic cap_edge;
  logic sh_edge;
  logic [LEN_W-1:0] len;
  logic [3:0] len_m1;
  logic [WORD_MAX:0] mask_wide;
  logic [WORD_MAX-1:0] wmask;

  // modes 1 and 2 capture on falling sck; modes 1 and 3 shift on the first edge
  assign cpha = mode_i[0] ^ mode_i[1];
  assign sck_rise = pins.sck & ~s.sck_q;
  assign sck_fall = ~pins.sck & s.sck_q;
  assign cs_fall = s.cs_n_q & ~pins.cs_n;
  assign cs_rise = ~s.cs_n_q & pins.cs_n;
  // edges count only inside a selected frame
  assign cap_edge = s.active & ~cs_rise & (cpha ? sck_fall : sck_rise);
  assign sh_edge = s.active & ~cs_rise & (cpha ? sck_rise : sck_fall);

  always_comb begin
    if (word_len_i < LEN_MIN) begin
      len = LEN_MIN;
    end else if (word_len_i > LEN_MAX) begin
      len = LEN_MAX;
    end else begin
      len = word_len_i;
    end
  end

  assign len_m1 = 4'(len - 5'h01);
  assign mask_wide = ((WORD_MAX+1)'(1) << len) - (WORD_MAX+1)'(1);
  assign wmask = mask_wide[WORD_MAX-1:0];

  // ==========================================================
  // received word buffer
  logic rx_in_ready;
  logic rx_valid;
  logic [WORD_MAX-1:0] rx_data;

  word_buffer #(
    .WIDTH(WORD_MAX),
    .DEPTH(RX_DEPTH)
  ) u_rx_buffer (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .in_valid_i(s.rx_push),
    .in_data_i(s.rx_word),
    .in_ready_o(rx_in_ready),
    .out_valid_o(rx_valid),
    .out_data_o(rx_data),
    .out_ready_i(rx_ready_i)
  );

  assign rx_o = '{valid: rx_valid, data: rx_data};

  // ==========================================================
  // next state
  logic [WORD_MAX-1:0] rx_full;
  logic [DATA_BITS-1:0] dw_full;
  logic [CODE_BITS-1:0] code;
  logic [FBIT_W-1:0] dbit;
  logic data_phase;
  logic word_done;
  logic dword_done;

  assign rx_full = {s.shift[WORD_MAX-2:0], pins.mosi} & wmask;
  assign dw_full = {s.dword[DATA_BITS-2:0], pins.mosi};
  assign code = s.hdr[CODE_BITS-1:0];
  assign data_phase = (s.fbit >= FBIT_W'(HDR_BITS));
  assign dbit = s.fbit - FBIT_W'(HDR_BITS);
  assign word_done = cap_edge & (s.bit_cnt[3:0] == len_m1);
  assign dword_done = cap_edge & data_phase & (dbit[4:0] == 5'h1F);

  always_comb begin
    logic [FBIT_W-1:0] ridx;
    logic [KEY_BITS-1:0] tamp;
    logic readout;
    ridx = '0;
    tamp = '0;
    readout = 1'b0;
    next_s = s;
    next_s.sck_q = pins.sck;
    next_s.cs_n_q = pins.cs_n;
    next_s.rx_push = 1'b0;

    // frame start: arm clock, load any waiting transmit word
    if (cs_fall) begin
      next_s.active = 1'b1;
      next_s.bit_cnt = '0;
      next_s.fbit = '0;
      next_s.out_idx = '0;
      next_s.hdr = '0;
      next_s.dword = '0;
      next_s.skip = mode_i[0];
      next_s.tx_fresh = 1'b0;
      if (s.hold_valid) begin
        next_s.shift = s.hold;
        next_s.hold_valid = 1'b0;
      end
    end

    // frame end: partial word and frame position dropped
    if (cs_rise) begin
      next_s.active = 1'b0;
      next_s.bit_cnt = '0;
      next_s.fbit = '0;
      next_s.out_idx = '0;
    end

    // capture edge: one bit in per sck pulse
    if (cap_edge) begin
      next_s.cap_bit = pins.mosi;
      next_s.bit_cnt = s.bit_cnt + 5'h01;
      if (s.fbit != FBIT_MAX) begin
        next_s.fbit = s.fbit + 12'h001;
      end
      if (!data_phase) begin
        next_s.hdr = {s.hdr[HDR_BITS-2:0], pins.mosi};
      end else begin
        next_s.dword = dw_full;
      end
    end

    // shift edge: next bit onto miso unless this edge only opens the word
    if (sh_edge) begin
      next_s.out_idx = s.fbit;
      if (s.skip) begin
        next_s.skip = 1'b0;
      end else begin
        next_s.shift = {s.shift[WORD_MAX-2:0], s.cap_bit};
      end
    end

    // word complete: hand it to the core, keep it for retransmission unless a held word is waiting
    if (word_done) begin
      next_s.bit_cnt = '0;
      next_s.skip = 1'b1;
      next_s.rx_word = rx_full;
      next_s.rx_push = 1'b1;
      if (s.hold_valid) begin
        next_s.shift = s.hold;
        next_s.hold_valid = 1'b0;
      end else begin
        next_s.shift = rx_full;
      end
    end

    // bootloader command on each complete data word
    if (dword_done) begin
      if (code == CODE_UNLOCK) begin
        if (s.unlock == LOCKED && dw_full == UNLOCK_FIRST) begin
          next_s.unlock = HALF_OPEN;
        end else if (s.unlock == HALF_OPEN && dw_full == UNLOCK_SECOND) begin
          next_s.unlock = OPEN;
        end else if (s.unlock != OPEN) begin
          next_s.unlock = LOCKED;
        end
      end else if (s.unlock == OPEN) begin
        if (code == CODE_READ_DEC) begin
          next_s.tamper_dec = fuse_i.decryption_key;
          next_s.sel = TAMP_DEC;
        end else if (code == CODE_READ_AUTH) begin
          next_s.tamper_auth = fuse_i.auth_key;
          next_s.sel = TAMP_AUTH;
        end else if (code == CODE_READ_CTRL) begin
          next_s.tamper_ctrl = fuse_i.ctrl;
          next_s.sel = TAMP_CTRL;
        end
      end
    end

    // core writes: direct load when idle and nothing fresh, else holding word
    if (tx_i.valid) begin
      if (!s.tx_fresh && !s.hold_valid && !s.active && !cs_fall) begin
        next_s.shift = tx_i.data;
        next_s.tx_fresh = 1'b1;
      end else begin
        next_s.hold = tx_i.data;
        next_s.hold_valid = 1'b1;
      end
    end

    // overrun when a word finds the buffer full; cleared by a new frame
    if (s.rx_push && !rx_in_ready) begin
      next_s.overrun = 1'b1;
    end else if (cs_fall) begin
      next_s.overrun = 1'b0;
    end

    // miso source: tamper readout during 0011 data words, else shift msb
    case (s.sel)
      TAMP_DEC: tamp = s.tamper_dec;
      TAMP_AUTH: tamp = s.tamper_auth;
      TAMP_CTRL: tamp = {s.tamper_ctrl, {(KEY_BITS-CTRL_BITS){1'b0}}};
      default: tamp = '0;
    endcase
    ridx = next_s.out_idx - FBIT_W'(HDR_BITS);
    readout = (s.unlock == OPEN) && (next_s.hdr[CODE_BITS-1:0] == CODE_READOUT)
      && (next_s.out_idx >= FBIT_W'(HDR_BITS))
      && (ridx < FBIT_W'(KEY_BITS));
    if (readout) begin
      next_s.miso = tamp[7'(KEY_BITS - 1) - ridx[6:0]];
    end else begin
      next_s.miso = next_s.shift[len_m1];
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
      s.cs_n_q <= 1'b1;
      s.shift <= SHIFT_RESET;
      s.unlock <= LOCKED;
      s.sel <= TAMP_DEC;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign spi_o = '{miso: s.miso, miso_oe: s.active};
  assign tx_ready_o = 1'b1;
  assign overrun_o = s.overrun;
  assign unlocked_o = (s.unlock == OPEN);
  assign busy_o = s.active;

endmodule : spi_client_fuse_readout

// ### sim/spi_client_fuse_readout_checker.sv
/* port checker for spi_client_fuse_readout
   assumes it is bound into every instance of that module */
`timescale 1ns/1ps
module spi_client_fuse_readout_checker (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire spi_fuse_pkg::spi_in_type spi_i,
  input wire spi_fuse_pkg::spi_out_type spi_o,
  input wire logic [1:0] mode_i,
  input wire logic [spi_fuse_pkg::LEN_W-1:0] word_len_i,
  input wire spi_fuse_pkg::word_type tx_i,
  input wire spi_fuse_pkg::word_type rx_o,
  input wire logic rx_ready_i,
  input wire logic overrun_o,
  input wire logic unlocked_o,
  input wire logic busy_o
);
  import spi_fuse_pkg::*;
  // ==========================================
  // sequences
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  sequence off_s;
    spi_i.cs_n [*5];
  endsequence
  sequence on_s;
    (!spi_i.cs_n) [*5];
  endsequence
  sequence quiet_s;
    (spi_i.cs_n && !tx_i.valid && $stable(word_len_i) && $stable(mode_i)) [*6];
  endsequence
  // ==========================================
  // assertions
  deselect_off_a: assert property (off_s |-> !spi_o.miso_oe && !busy_o)
    else $error("output enabled while deselected");
  select_on_a: assert property (on_s |-> spi_o.miso_oe && busy_o)
    else $error("select not followed by frame");
  idle_miso_a: assert property (quiet_s |-> $stable(spi_o.miso))
    else $error("miso moved while deselected");
  rx_hold_a: assert property (rx_o.valid && !rx_ready_i |=> rx_o.valid && $stable(rx_o.data))
    else $error("received word dropped while stalled");
  rx_push_a: assert property ($rose(rx_o.valid) |-> busy_o)
    else $error("word pushed outside a frame");
  unlock_keep_a: assert property (unlocked_o |=> unlocked_o)
    else $error("unlock lost");
  unlock_frame_a: assert property ($rose(unlocked_o) |-> busy_o)
    else $error("unlock outside a frame");
  overrun_clear_a: assert property ($fell(spi_i.cs_n) ##1 (!spi_i.cs_n) [*4] |-> !overrun_o)
    else $error("overrun kept after select");
endmodule : spi_client_fuse_readout_checker

bind spi_client_fuse_readout spi_client_fuse_readout_checker i_checker (
  .mclk_i(mclk_i), .reset_i(reset_i), .spi_i(spi_i), .spi_o(spi_o), .mode_i(mode_i),
  .word_len_i(word_len_i), .tx_i(tx_i), .rx_o(rx_o), .rx_ready_i(rx_ready_i),
  .overrun_o(overrun_o), .unlocked_o(unlocked_o), .busy_o(busy_o)
);

// ### sim/spi_host_model.sv
/* host side of the serial bus, four modes, 200 ns bit time
   assumes pins change only at falling edges of mclk_i */
`timescale 1ns/1ps
module spi_host_model (
  input wire logic mclk_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic cs_n_o
);
  // ==========================================
  // bus driver
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    cs_n_o = 1'b1; // single client, deselected at start
  end
  task automatic half();
    repeat (4) @(negedge mclk_i); // 4 clocks a level, 5 MHz sck: core needs 3 clocks per level
  endtask : half
  task automatic frame(input logic [1:0] m, input int n, input logic [255:0] d,
                       output logic [255:0] q);
    q = '0;
    sck_o = m[1]; // idle level of the mode
    half();
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin // one pulse a bit
      if (!m[0]) mosi_o = d[i];
      half();
      sck_o = ~sck_o;
      if (m[0]) mosi_o = d[i];
      else q[i] = miso_i;
      half();
      sck_o = ~sck_o;
      if (m[0]) q[i] = miso_i;
    end
    half();
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line shows no stale bit
  endtask : frame
endmodule : spi_host_model

// ### sim/testbench.sv
/* self-checking bench for spi_client_fuse_readout
   assumes spi_host_model and the bound checker are compiled first */
`timescale 1ns/1ps
module testbench;
  import spi_fuse_pkg::*;
  // ==========================================
  // signals
  localparam fuse_bank_type FUSE_VALUE = {128'h0123456789ABCDEF0011223344556677,
    128'hFEDCBA9876543210A5A55A5AC3C33C3C, 32'h13579BDF};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [LEN_W-1:0] len = 5'h10;
  logic rx_ready = 1'b1;
  word_type tx = '0;
  word_type rx;
  spi_in_type spi_in;
  spi_out_type spi_out;
  logic sck, mosi, cs_n, tx_ready, overrun, unlocked, busy;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [15:0] rxq[$];
  assign spi_in = {sck, mosi, cs_n};
  spi_client_fuse_readout i_dut (
    .mclk_i(mclk), .reset_i(rst), .spi_i(spi_in), .spi_o(spi_out), .mode_i(mode),
    .word_len_i(len), .tx_i(tx), .tx_ready_o(tx_ready), .rx_o(rx), .rx_ready_i(rx_ready),
    .fuse_i(FUSE_VALUE), .overrun_o(overrun), .unlocked_o(unlocked), .busy_o(busy)
  );
  spi_host_model i_host (
    .mclk_i(mclk), .miso_i(spi_out.miso), .sck_o(sck), .mosi_o(mosi), .cs_n_o(cs_n)
  );
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (rx.valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx.data);
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic rx_is(input logic [15:0] exp, input logic [15:0] msk);
    logic [15:0] got;
    got = (rxq.size() > 0) ? rxq.pop_front() & msk : 16'hXXXX;
    chk(got, exp & msk);
  endtask : rx_is
  task automatic wr(input logic [15:0] d);
    @(negedge mclk);
    tx = {1'b1, d};
    @(negedge mclk);
    tx.valid = 1'b0;
  endtask : wr
  task automatic xfer(input logic [1:0] m, input logic [4:0] l, input int n,
                      input logic [255:0] d, output logic [255:0] q);
    @(negedge mclk);
    mode = m;
    len = l;
    i_host.frame(m, n, d, q);
    repeat (8) @(negedge mclk);
  endtask : xfer
  task automatic boot(input logic [15:0] c, input int nw, input logic [127:0] w,
                      output logic [255:0] q);
    xfer(2'h0, 5'h10, 48 + 32 * nw, ({240'h0, c} << (32 * nw)) | {128'h0, w}, q);
  endtask : boot
  task automatic readback(input logic [15:0] c, input logic [127:0] exp);
    logic [255:0] q;
    boot(c, 1, '0, q);
    boot(CODE_READOUT, 4, '0, q);
    chk(q[127:0], exp);
  endtask : readback
  // ==========================================
  // scenarios
  task automatic sc_reset_zero();
    logic [255:0] q;
    xfer(2'h0, 5'h10, 16, 256'hA5C3, q);
    chk(q[15:0], 16'h0000);
    rx_is(16'hA5C3, 16'hFFFF);
  endtask : sc_reset_zero
  task automatic sc_modes();
    logic [255:0] q;
    for (int m = 0; m < 4; m++) begin
      wr(16'h00C0 + 16'(m));
      xfer(2'(m), 5'h08, 8, 256'h96 ^ 256'(m), q);
      chk(q[7:0], 8'hC0 + 8'(m));
      rx_is(16'h0096 ^ 16'(m), 16'h00FF);
      xfer(2'(m), 5'h08, 8, 256'h5A, q);
      chk(q[7:0], 8'h96 ^ 8'(m));
      rx_is(16'h005A, 16'h00FF);
    end
  endtask : sc_modes
  task automatic sc_hold();
    logic [255:0] q;
    wr(16'h0011);
    wr(16'h0022);
    wr(16'h0033);
    chk(tx_ready, 1'b1);
    xfer(2'h3, 5'h08, 8, 256'h0, q);
    chk(q[7:0], 8'h33);
    rx_is(16'h0000, 16'h00FF);
  endtask : sc_hold
  task automatic sc_overrun();
    logic [255:0] q;
    rx_ready = 1'b0;
    xfer(2'h1, 5'h08, 24, 256'h1A2B3C, q);
    chk(overrun, 1'b1);
    rx_ready = 1'b1;
    repeat (4) @(negedge mclk);
    rx_is(16'h001A, 16'h00FF);
    rx_is(16'h002B, 16'h00FF);
    chk(rxq.size(), 0);
    xfer(2'h2, 5'h08, 12, 256'hABC, q);
    chk(q[11:4], 8'h3C);
    chk(overrun, 1'b0);
    rx_is(16'h00AB, 16'h00FF);
    chk(rxq.size(), 0);
  endtask : sc_overrun
  task automatic sc_boot();
    logic [255:0] q;
    boot(CODE_READ_CTRL, 1, '0, q);
    chk(unlocked, 1'b0);
    boot(CODE_UNLOCK, 1, {96'h0, UNLOCK_FIRST}, q);
    chk(unlocked, 1'b0);
    boot(CODE_UNLOCK, 1, {96'h0, UNLOCK_SECOND}, q);
    chk(unlocked, 1'b1);
    readback(CODE_READ_DEC, FUSE_VALUE.decryption_key);
    readback(CODE_READ_AUTH, FUSE_VALUE.auth_key);
    readback(CODE_READ_CTRL, {FUSE_VALUE.ctrl, 96'h0});
    rxq.delete();
  endtask : sc_boot
  task automatic sc_rereset();
    logic [255:0] q;
    @(negedge mclk);
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk(unlocked, 1'b0);
    xfer(2'h1, 5'h08, 8, 256'h3D, q);
    chk(q[7:0], 8'h00);
    rx_is(16'h003D, 16'h00FF);
  endtask : sc_rereset
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    sc_reset_zero();
    sc_modes();
    sc_hold();
    sc_overrun();
    sc_boot();
    sc_rereset();
    complete_run();
  end
endmodule : testbench
